// *** verilog/evflag_pkg.sv ***
// constants, field positions and carrier types of the event and flag block
// assumes a single 100 MHz clock and an apb slave with 8-bit byte addresses
package evflag_pkg;

  localparam int NUM_EV   = 23;
  localparam int EV_IDX_W = 5;
  localparam int EV_NUM_W = 6;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_SYS_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_OP_FLAGS   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_EV_STATUS  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_EV_MASK    = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_TOP_EVENT  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_EV_ACK     = 8'h14;

  // system status byte fields
  localparam int ALWAYS_ON_BIT   = 0;
  localparam int FIRST_SCAN_BIT  = 1;
  localparam int RETAIN_LOST_BIT = 2;
  localparam int POWER_UP_BIT    = 3;
  localparam int SLOW_CLOCK_BIT  = 4;
  localparam int FAST_CLOCK_BIT  = 5;
  localparam int SCAN_TOGGLE_BIT = 6;
  localparam int RUN_SWITCH_BIT  = 7;

  // operation result flag fields
  localparam int ZERO_BIT      = 0;
  localparam int OVERFLOW_BIT  = 1;
  localparam int NEGATIVE_BIT  = 2;
  localparam int DIV_ERR_BIT   = 3;
  localparam int TABLE_FULL_BIT  = 4;
  localparam int TABLE_EMPTY_BIT = 5;
  localparam int BCD_ERR_BIT   = 6;
  localparam int TEXT_ERR_BIT  = 7;

  localparam int ACK_BIT = 0;

  localparam logic [7:0]        BYTE_RESET = 8'h00;
  localparam logic [NUM_EV-1:0] EV_RESET   = 23'h000000;

  // timing
  localparam longint CLK_HZ       = 100_000_000;
  localparam longint SLOW_HALF_S  = 30;
  localparam longint FAST_HALF_MS = 500;
  localparam logic [31:0] SLOW_HALF_CYC = 32'(SLOW_HALF_S * CLK_HZ);
  localparam logic [31:0] FAST_HALF_CYC = 32'(FAST_HALF_MS * CLK_HZ / 1000);

  typedef enum logic [1:0] {grp_comm, grp_discrete, grp_timed} group_t;

  typedef struct packed {
    logic        valid;
    group_t      grp;
    logic [4:0]  prio;
    logic [EV_NUM_W-1:0] num;
  } top_event_t;

  typedef struct packed {
    logic        done;
    logic [31:0] result;
    logic        overflow;
    logic        illegal;
    logic        div_zero;
    logic        bcd_err;
    logic        text_err;
    logic        table_full;
    logic        table_empty;
  } op_status_t;

  // lowest service priority first, so the last field lands in bit 0
  typedef struct packed {
    logic timer_b_done;
    logic timer_a_done;
    logic periodic_1;
    logic periodic_0;
    logic cnt5_equal;
    logic cnt4_ext_reset;
    logic cnt4_dir_change;
    logic cnt4_equal;
    logic cnt3_equal;
    logic cnt1_ext_reset;
    logic cnt1_dir_change;
    logic cnt1_equal;
    logic cnt0_ext_reset;
    logic cnt0_dir_change;
    logic cnt0_equal;
    logic pulse1_done;
    logic pulse0_done;
    logic port1_tx_done;
    logic port1_rx_char;
    logic port1_rx_msg;
    logic port0_rx_msg;
    logic port0_tx_done;
    logic port0_rx_char;
  } event_src_t;

endpackage

// *** verilog/event_picker.sv ***
// picks the pending event with the best service position
// assumes bit 0 is served first; purely combinational
module event_picker
  import evflag_pkg::*;
(
  input  wire logic [NUM_EV-1:0]   pend,
  output logic                     found,
  output logic [EV_IDX_W-1:0]      idx
);

  always_comb begin
    found = 1'b0;
    idx   = '0;
    // scan downward so the lowest index wins
    for (int i = NUM_EV - 1; i >= 0; i--) begin
      if (pend[i]) begin
        found = 1'b1;
        idx   = EV_IDX_W'(i);
      end
    end
  end

endmodule

// *** verilog/square_wave.sv ***
// free-running square wave, low for half_cyc cycles then high as long
// assumes half_cyc is at least one
module square_wave
  import evflag_pkg::*;
#(
  parameter logic [31:0] HALF_CYC = FAST_HALF_CYC
) (
  input  wire logic clk,
  input  wire logic reset,
  output logic      wave
);

  logic [31:0] cnt_r;
  logic        wave_r;
  logic        wrap;

  assign wrap = (cnt_r == HALF_CYC - 32'h1);
  assign wave = wave_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_r  <= 32'h0;
      wave_r <= 1'b0;
    end else begin
      cnt_r  <= wrap ? 32'h0 : cnt_r + 32'h1;
      wave_r <= wrap ? ~wave_r : wave_r;
    end
  end

endmodule

// *** verilog/event_flags.sv ***
// event prioritiser plus system status and operation result bytes
// assumes event pulses come from logic on clk; switch pins are asynchronous
// software reaches everything over apb with one wait state per access

// What this block does
// - events fall into communications, discrete, timed groups, served in that order
// - port zero raises 8, 9, 23, all at communications priority 0
// - port one raises 24, 25, 26, all at communications priority 1
// - pulse train zero and one done raise 19 and 20, discrete 0 and 1
// - fast counter zero raises 12, 27, 28 at discrete 10, 11, 12
// - fast counter one raises 13, 14, 15 at discrete 13, 14, 15
// - fast counter three raises 32 on count equal preset, discrete 19
// - fast counter four raises 29, 30, 31 at discrete 20, 21, 22
// - fast counter five raises 33 on equal preset, lowest discrete at 23
// - timed group raises 10, 11, 21, 22 in ascending priority
// - fast clock bit is a square wave, 0.5 s low then 0.5 s high
// - scan toggle bit inverts once per program scan
// - run switch bit follows the mode switch run position
// - each operation sets zero flag on zero result, negative on negative
// - overflow flag on overflow or illegal value, divide flag on zero divisor
// - decimal conversion error flag set when bcd to binary fails
// - text conversion error flag set when character to hex fails
module event_flags
  import evflag_pkg::*;
#(
  parameter logic [31:0] SLOW_HALF_CYCLES = SLOW_HALF_CYC,
  parameter logic [31:0] FAST_HALF_CYCLES = FAST_HALF_CYC
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire event_src_t        ev_src,
  input  wire logic              scan_end,
  input  wire op_status_t        op_status,
  input  wire logic              run_switch_pin,
  input  wire logic              retain_lost_pin,
  output logic                   irq
);

  // service order table: index 0 is served first
  function automatic top_event_t ev_info(input logic [EV_IDX_W-1:0] i);
    top_event_t t;
    t = '0;
    unique case (i)
      5'd0:  t = '{1'b1, grp_comm,     5'd0,  6'd8};
      5'd1:  t = '{1'b1, grp_comm,     5'd0,  6'd9};
      5'd2:  t = '{1'b1, grp_comm,     5'd0,  6'd23};
      5'd3:  t = '{1'b1, grp_comm,     5'd1,  6'd24};
      5'd4:  t = '{1'b1, grp_comm,     5'd1,  6'd25};
      5'd5:  t = '{1'b1, grp_comm,     5'd1,  6'd26};
      5'd6:  t = '{1'b1, grp_discrete, 5'd0,  6'd19};
      5'd7:  t = '{1'b1, grp_discrete, 5'd1,  6'd20};
      5'd8:  t = '{1'b1, grp_discrete, 5'd10, 6'd12};
      5'd9:  t = '{1'b1, grp_discrete, 5'd11, 6'd27};
      5'd10: t = '{1'b1, grp_discrete, 5'd12, 6'd28};
      5'd11: t = '{1'b1, grp_discrete, 5'd13, 6'd13};
      5'd12: t = '{1'b1, grp_discrete, 5'd14, 6'd14};
      5'd13: t = '{1'b1, grp_discrete, 5'd15, 6'd15};
      5'd14: t = '{1'b1, grp_discrete, 5'd19, 6'd32};
      5'd15: t = '{1'b1, grp_discrete, 5'd20, 6'd29};
      5'd16: t = '{1'b1, grp_discrete, 5'd21, 6'd30};
      5'd17: t = '{1'b1, grp_discrete, 5'd22, 6'd31};
      5'd18: t = '{1'b1, grp_discrete, 5'd23, 6'd33};
      5'd19: t = '{1'b1, grp_timed,    5'd0,  6'd10};
      5'd20: t = '{1'b1, grp_timed,    5'd1,  6'd11};
      5'd21: t = '{1'b1, grp_timed,    5'd2,  6'd21};
      5'd22: t = '{1'b1, grp_timed,    5'd3,  6'd22};
      default: t = '0;
    endcase
    return t;
  endfunction

  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    return (a == OFS_SYS_STATUS) || (a == OFS_OP_FLAGS) ||
           (a == OFS_EV_STATUS)  || (a == OFS_EV_MASK)  ||
           (a == OFS_TOP_EVENT)  || (a == OFS_EV_ACK);
  endfunction

  // ---- pin synchronisers
  logic [1:0] pin_meta_r;
  logic [1:0] pin_sync_r;
  wire        run_switch_s  = pin_sync_r[1];
  wire        retain_lost_s = pin_sync_r[0];

  // first flop may go metastable; only the second one is read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_meta_r <= 2'h0;
    end else begin
      pin_meta_r <= {run_switch_pin, retain_lost_pin};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_sync_r <= 2'h0;
    end else begin
      pin_sync_r <= pin_meta_r;
    end
  end

  // ---- square-wave clocks
  logic slow_wave;
  logic fast_wave;

  square_wave #(
    .HALF_CYC (SLOW_HALF_CYCLES)
  ) u_slow (
    .clk   (clk),
    .reset (reset),
    .wave  (slow_wave)
  );

  square_wave #(
    .HALF_CYC (FAST_HALF_CYCLES)
  ) u_fast (
    .clk   (clk),
    .reset (reset),
    .wave  (fast_wave)
  );

  // ---- system status byte
  logic       scan_toggle_r;
  logic       first_scan_r;
  logic [7:0] sys_status_r;
  logic [7:0] sys_status_nxt;

  always_comb begin
    sys_status_nxt                  = BYTE_RESET;
    sys_status_nxt[ALWAYS_ON_BIT]   = 1'b1;
    sys_status_nxt[FIRST_SCAN_BIT]  = first_scan_r;
    sys_status_nxt[RETAIN_LOST_BIT] = retain_lost_s;
    sys_status_nxt[POWER_UP_BIT]    = first_scan_r;
    sys_status_nxt[SLOW_CLOCK_BIT]  = slow_wave;
    sys_status_nxt[FAST_CLOCK_BIT]  = fast_wave;
    sys_status_nxt[SCAN_TOGGLE_BIT] = scan_toggle_r;
    sys_status_nxt[RUN_SWITCH_BIT]  = run_switch_s;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scan_toggle_r <= 1'b0;
    end else begin
      scan_toggle_r <= scan_toggle_r ^ scan_end;
    end
  end

  // first scan lasts until the first scan end after reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      first_scan_r <= 1'b1;
    end else begin
      first_scan_r <= first_scan_r & ~scan_end;
    end
  end

  // registered so the byte reads as one coherent snapshot
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sys_status_r <= BYTE_RESET;
    end else begin
      sys_status_r <= sys_status_nxt;
    end
  end

  // ---- operation result flags
  logic [7:0] op_flags_r;
  logic [7:0] op_flags_nxt;

  always_comb begin
    op_flags_nxt                  = op_flags_r;
    if (op_status.done) begin
      op_flags_nxt[ZERO_BIT]        = (op_status.result == 32'h0);
      op_flags_nxt[NEGATIVE_BIT]    = op_status.result[DATA_W-1];
      op_flags_nxt[OVERFLOW_BIT]    = op_status.overflow |
                                      op_status.illegal;
      op_flags_nxt[DIV_ERR_BIT]     = op_status.div_zero;
      op_flags_nxt[TABLE_FULL_BIT]  = op_status.table_full;
      op_flags_nxt[TABLE_EMPTY_BIT] = op_status.table_empty;
      op_flags_nxt[BCD_ERR_BIT]     = op_status.bcd_err;
      op_flags_nxt[TEXT_ERR_BIT]    = op_status.text_err;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      op_flags_r <= BYTE_RESET;
    end else begin
      op_flags_r <= op_flags_nxt;
    end
  end

  // ---- apb handshake: one wait state, data and error registered
  logic              pready_r;
  logic              pslverr_r;
  logic [DATA_W-1:0] prdata_r;

  wire setup_acc = psel & penable & ~pready_r;
  wire commit    = psel & penable & pready_r;
  wire wr_commit = commit & pwrite;
  wire rd_commit = commit & ~pwrite;
  wire known     = addr_known(paddr);

  // one select per register, shared by side effects and the read mux
  wire sel_sys   = (paddr == OFS_SYS_STATUS);
  wire sel_flags = (paddr == OFS_OP_FLAGS);
  wire sel_stat  = (paddr == OFS_EV_STATUS);
  wire sel_mask  = (paddr == OFS_EV_MASK);
  wire sel_top   = (paddr == OFS_TOP_EVENT);
  wire sel_ack   = (paddr == OFS_EV_ACK);

  // ---- event status, mask and service pick
  logic [NUM_EV-1:0]   ev_status_r;
  logic [NUM_EV-1:0]   ev_mask_r;
  logic [NUM_EV-1:0]   ev_set;
  logic [NUM_EV-1:0]   ev_clr;
  logic [NUM_EV-1:0]   ev_onehot;
  logic [EV_IDX_W-1:0] top_idx_r;
  top_event_t          top_r;
  logic                irq_r;
  logic                pick_found;
  logic [EV_IDX_W-1:0] pick_idx;

  assign ev_set = ev_src;

  event_picker u_pick (
    .pend  (ev_status_r & ev_mask_r),
    .found (pick_found),
    .idx   (pick_idx)
  );

  wire top_valid_nxt = pick_found;
  wire ack_wr   = wr_commit & sel_ack & pwdata[ACK_BIT];
  wire stat_rd  = rd_commit & sel_stat;
  wire mask_wr  = wr_commit & sel_mask;

  assign ev_onehot = NUM_EV'(1) << top_idx_r;

  // a status read clears only what the read returned, so late events survive
  assign ev_clr = (stat_rd ? prdata_r[NUM_EV-1:0] : EV_RESET) |
                  ((ack_wr & top_r.valid) ? ev_onehot : EV_RESET);

  wire [NUM_EV-1:0] ev_status_nxt = (ev_status_r & ~ev_clr) | ev_set;
  wire [NUM_EV-1:0] ev_mask_nxt   = mask_wr ? pwdata[NUM_EV-1:0] : ev_mask_r;
  top_event_t       top_nxt;
  wire              irq_nxt       = |(ev_status_r & ev_mask_r);

  assign top_nxt = top_valid_nxt ? ev_info(pick_idx) : '0;

  // set wins over a clear that lands in the same cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ev_status_r <= EV_RESET;
    end else begin
      ev_status_r <= ev_status_nxt;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ev_mask_r <= EV_RESET;
    end else begin
      ev_mask_r <= ev_mask_nxt;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      top_idx_r <= '0;
    end else begin
      top_idx_r <= pick_idx;
    end
  end

  // top and index move together so an ack clears what was shown
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      top_r <= '0;
    end else begin
      top_r <= top_nxt;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // ---- read mux
  wire [DATA_W-1:0] sys_word   = {24'h0, sys_status_r};
  wire [DATA_W-1:0] flags_word = {24'h0, op_flags_r};
  wire [DATA_W-1:0] stat_word  = {9'h0, ev_status_r};
  wire [DATA_W-1:0] mask_word  = {9'h0, ev_mask_r};
  wire [DATA_W-1:0] top_word   = {18'h0, top_r};

  // unmapped offsets and the ack register read as zero
  wire [DATA_W-1:0] rd_mux =
    sel_sys   ? sys_word :
    sel_flags ? flags_word :
    sel_stat  ? stat_word :
    sel_mask  ? mask_word :
    sel_top   ? top_word :
    32'h0;

  wire [DATA_W-1:0] prdata_nxt = setup_acc ? (pwrite ? 32'h0 : rd_mux) : prdata_r;

  // pready lasts one cycle; an access held past it completes again two cycles later
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= setup_acc;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= setup_acc & ~known;
    end
  end

  // read data held until the next access so a slow master still sees it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata_r <= 32'h0;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign irq     = irq_r;

endmodule

// *** tb/event_flags_sva.sv ***
// port-level checker for event_flags: apb handshake, irq and read layouts
// assumes one clock domain; mask is mirrored from observed apb writes
module event_flags_sva
  import evflag_pkg::*;
(
  input wire logic              clk,
  input wire logic              reset,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire event_src_t        ev_src,
  input wire logic              irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [NUM_EV-1:0] mask_r;
  wire               bad_addr = (paddr > OFS_EV_ACK) || (paddr[1:0] != 2'h0);
  wire               rd_done  = pready && !pwrite && !pslverr;

  // mirror of the mask, taken at the completing edge only
  always_ff @(posedge clk or posedge reset) begin
    if (reset) mask_r <= '0;
    else if (psel && penable && pready && pwrite && paddr == OFS_EV_MASK)
      mask_r <= pwdata[NUM_EV-1:0];
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_acc1;
    psel && penable && !pready;
  endsequence
  sequence s_acc_bad;
    s_acc1 ##0 bad_addr;
  endsequence
  sequence s_acc_good;
    s_acc1 ##0 !bad_addr;
  endsequence

  a_ready_after_wait: assert property (s_acc1 |=> pready)
    else $error("pready missing after first access cycle");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  a_err_bad_addr: assert property (s_acc_bad |=> pslverr && prdata == '0)
    else $error("unmapped access not refused");
  a_no_err_mapped: assert property (s_acc_good |=> !pslverr)
    else $error("mapped access refused");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_top_layout: assert property (rd_done && paddr == OFS_TOP_EVENT |->
    prdata[31:14] == '0 && prdata[12:11] != 2'h3)
    else $error("top event word malformed");
  a_sys_always_on: assert property (rd_done && paddr == OFS_SYS_STATUS |->
    prdata[0] && prdata[31:8] == '0)
    else $error("system status word malformed");
  a_irq_on_event: assert property ((ev_src & mask_r) != '0 |-> ##[1:2] irq)
    else $error("unmasked event raised no irq");
  a_irq_masked_low: assert property ((mask_r == '0) [*3] |-> !irq)
    else $error("irq high while all masked");
endmodule

bind event_flags event_flags_sva i_sva (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .ev_src(ev_src), .irq(irq)
);

// *** tb/event_flags_tb.sv ***
// self-checking bench for event_flags, driving every port directly except retain_lost_pin, tied low
// assumes shortened square-wave halves; bus waits rely on pready alone
module event_flags_tb
  import evflag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int  SLOW = 20;
  localparam int  FAST = 5;
  localparam byte NUMS [NUM_EV] = '{8, 9, 23, 24, 25, 26, 19, 20, 12, 27, 28, 13, 14, 15,
                                    32, 29, 30, 31, 33, 10, 11, 21, 22};
  localparam byte PRI [NUM_EV]  = '{0, 0, 0, 1, 1, 1, 0, 1, 10, 11, 12, 13, 14, 15,
                                    19, 20, 21, 22, 23, 0, 1, 2, 3};
  localparam int  PA [4]        = '{6, 3, 0, 8};
  localparam int  PB [4]        = '{22, 18, 3, 14};
  logic              clk = 1'b0;
  logic              reset = 1'b1;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  event_src_t        ev_src = '0;
  logic              scan_end = 1'b0;
  op_status_t        op_status = '0;
  logic              run_switch_pin = 1'b0;
  logic              irq;
  logic [DATA_W-1:0] q;
  logic              eq;
  int                errors = 0;
  int                n_tests = 0;

  event_flags #(.SLOW_HALF_CYCLES(32'(SLOW)), .FAST_HALF_CYCLES(32'(FAST))) i_dut (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ev_src(ev_src), .scan_end(scan_end), .op_status(op_status),
    .run_switch_pin(run_switch_pin), .retain_lost_pin(1'b0), .irq(irq)
  );

  always #5 clk = ~clk;

  task automatic tally_and_finish();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // request held until pready is sampled; idle edge after avoids double drive
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    eq = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic pulse(input logic [NUM_EV-1:0] m);
    ev_src <= event_src_t'(m);
    @(posedge clk);
    ev_src <= '0;
    repeat (3) @(posedge clk);
  endtask

  task automatic t_irq();
    apb(1'b1, OFS_EV_MASK, '0);
    pulse(23'h10);
    cmp("irq masked", 32'h0, 32'(irq));
    apb(1'b0, OFS_EV_STATUS, '0);
    cmp("status", 32'h10, q);
    apb(1'b0, OFS_EV_STATUS, '0);
    cmp("status cleared", 32'h0, q);
    pulse(23'h10);
    apb(1'b1, OFS_EV_MASK, 32'h10);
    repeat (2) @(posedge clk);
    cmp("irq on", 32'h1, 32'(irq));
    apb(1'b0, OFS_EV_MASK, '0);
    cmp("mask", 32'h10, q);
    apb(1'b0, OFS_EV_STATUS, '0);
    repeat (2) @(posedge clk);
    cmp("irq off", 32'h0, 32'(irq));
    apb(1'b0, 8'h18, '0);
    cmp("unmapped data", 32'h0, q);
    cmp("unmapped err", 32'h1, 32'(eq));
  endtask

  // one event at a time, all unmasked, then acknowledged
  task automatic t_events();
    logic [1:0] g;
    apb(1'b1, OFS_EV_MASK, 32'h7fffff);
    for (int i = 0; i < NUM_EV; i++) begin
      g = (i < 6) ? 2'h0 : (i < 19) ? 2'h1 : 2'h2;
      pulse(23'h1 << i);
      cmp("irq", 32'h1, 32'(irq));
      apb(1'b0, OFS_TOP_EVENT, '0);
      cmp("top", {18'h0, 1'b1, g, 5'(PRI[i]), 6'(NUMS[i])}, q);
      apb(1'b1, OFS_EV_ACK, 32'h1);
      apb(1'b0, OFS_EV_STATUS, '0);
      cmp("acked", 32'h0, q);
    end
  endtask

  task automatic t_pairs();
    for (int i = 0; i < 4; i++) begin
      pulse((23'h1 << PA[i]) | (23'h1 << PB[i]));
      apb(1'b0, OFS_TOP_EVENT, '0);
      cmp("first", 32'(NUMS[PA[i]]), 32'(q[5:0]));
      apb(1'b1, OFS_EV_ACK, 32'h1);
      repeat (2) @(posedge clk);
      apb(1'b0, OFS_TOP_EVENT, '0);
      cmp("second", 32'(NUMS[PB[i]]), 32'(q[5:0]));
      apb(1'b0, OFS_EV_STATUS, '0);
    end
  endtask

  task automatic t_sys();
    logic s;
    apb(1'b0, OFS_SYS_STATUS, '0);
    s = q[SCAN_TOGGLE_BIT];
    cmp("scan reset", 32'h0, 32'(s));
    scan_end <= 1'b1;
    @(posedge clk);
    scan_end <= 1'b0;
    repeat (2) @(posedge clk);
    apb(1'b0, OFS_SYS_STATUS, '0);
    cmp("scan", 32'(!s), 32'(q[SCAN_TOGGLE_BIT]));
    run_switch_pin <= 1'b1;
    repeat (5) @(posedge clk);
    apb(1'b0, OFS_SYS_STATUS, '0);
    cmp("run on", 32'h1, 32'(q[RUN_SWITCH_BIT]));
    run_switch_pin <= 1'b0;
    repeat (5) @(posedge clk);
    apb(1'b0, OFS_SYS_STATUS, '0);
    cmp("run off", 32'h0, 32'(q[RUN_SWITCH_BIT]));
  endtask

  task automatic op_case(input logic [31:0] r, input logic [6:0] f, input logic [7:0] e);
    op_status <= op_status_t'({1'b1, r, f});
    @(posedge clk);
    op_status <= '0;
    repeat (2) @(posedge clk);
    apb(1'b0, OFS_OP_FLAGS, '0);
    cmp("flags", 32'(e), q);
  endtask

  // reads spaced one half period apart must see the bit flip every time
  task automatic t_wave(input int half, input int b);
    logic p;
    apb(1'b0, OFS_SYS_STATUS, '0);
    p = q[b];
    repeat (6) begin
      repeat (half - 4) @(posedge clk);
      apb(1'b0, OFS_SYS_STATUS, '0);
      cmp("wave", 32'(!p), 32'(q[b]));
      p = q[b];
    end
  endtask

  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_irq();
    t_events();
    t_pairs();
    t_sys();
    op_case(32'h0, 7'h00, 8'h01);
    op_case(32'h80000000, 7'h00, 8'h04);
    op_case(32'h5, 7'h40, 8'h02);
    op_case(32'h5, 7'h20, 8'h02);
    op_case(32'h5, 7'h08, 8'h40);
    op_case(32'h5, 7'h04, 8'h80);
    op_case(32'h0, 7'h10, 8'h09);
    apb(1'b1, OFS_OP_FLAGS, 32'hff);
    apb(1'b0, OFS_OP_FLAGS, '0);
    cmp("ro flags", 32'h9, q);
    t_wave(FAST, FAST_CLOCK_BIT);
    t_wave(SLOW, SLOW_CLOCK_BIT);
    tally_and_finish();
  end

  // whole run needs about 750 cycles
  initial begin
    #100us;
    errors++;
    tally_and_finish();
  end
endmodule
